// *** upstream_window_pkg.sv ***
`default_nettype none
package upstream_window_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_LIMIT_LOW    = 8'h50;
   localparam logic [7:0] OFF_BASE_HIGH    = 8'h54;
   localparam logic [7:0] OFF_LIMIT_HIGH   = 8'h58;
   localparam logic [7:0] OFF_ERR_DISABLE  = 8'h64;
   localparam logic [7:0] OFF_PORT1_GATING = 8'h68;
   localparam logic [7:0] OFF_PORT2_GATING = 8'h6c;
   localparam logic [7:0] OFF_ERR_CONTROL  = 8'h80;
   localparam logic [7:0] OFF_IRQ_STATUS   = 8'h84;
   localparam logic [7:0] OFF_IRQ_MASK     = 8'h88;

   // Field positions
   localparam int ADDR64_LSB      = 16;
   localparam int ADDR64_MSB      = 19;
   localparam int LIMIT_ADDR_LSB  = 20;
   localparam int LIMIT_ADDR_MSB  = 31;
   localparam int EVENT_LSB       = 1;
   localparam int EVENT_MSB       = 6;
   localparam int SERR_ENABLE_BIT = 0;
   localparam int GATING_MSB      = 15;

   // Reset and fixed values
   localparam logic [3:0]  ADDR64_INDICATOR = 4'h1;
   localparam logic [11:0] LIMIT_ADDR_RESET = 12'h000;
   localparam logic [31:0] UPPER_RESET      = 32'h0000_0000;
   localparam logic [5:0]  EVENT_RESET      = 6'h00;
   localparam logic [15:0] GATING_RESET     = 16'h0000;
   localparam logic        SERR_EN_RESET    = 1'b0;
   localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

   localparam int NUM_EVENTS      = 6;
   localparam int CLOCKS_PER_PORT = 8;

   // Bridge error events, MSB first in the order of the disable bits 6..1
   typedef struct packed {
      logic read_no_data;
      logic delayed_write_lost;
      logic master_abort_posted;
      logic target_abort_posted;
      logic posted_write_lost;
      logic posted_write_parity;
   } bridge_events_t;

   // Byte-lane merge for Wishbone writes
   function automatic logic [31:0] apply_sel(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  sel);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_val[8*i +: 8];
         end
      end
      return res;
   endfunction

   // A clock is off only when both bits of its field are set
   function automatic logic clock_disabled(input logic [1:0] field);
      return &field;
   endfunction

endpackage
`default_nettype wire

// *** clock_gate_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module clock_gate_bank
   import upstream_window_pkg::*;
#(
   parameter int COUNT = CLOCKS_PER_PORT
) (
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   input  wire logic               phase,
   input  wire logic [2*COUNT-1:0] gating,
   output var  logic [COUNT-1:0]   clock_out
);

   if (COUNT < 1 || COUNT > CLOCKS_PER_PORT) begin : g_bad_count
      $error("clock_gate_bank: COUNT out of range");
   end

   logic [COUNT-1:0] enable;

   for (genvar n = 0; n < COUNT; n++) begin : g_clk
      // Enable only moves as the divided clock falls
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            enable[n] <= 1'b1;
         end else if (phase) begin
            enable[n] <= ~clock_disabled(gating[2*n+1 -: 2]);
         end
      end

      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            clock_out[n] <= 1'b0;
         end else begin
            clock_out[n] <= phase ? 1'b0 : enable[n];
         end
      end

      property p_gate_off;
         @(posedge clk_sys) disable iff (sys_rst)
         clock_disabled(gating[2*n+1 -: 2]) [*3] |-> !clock_out[n];
      endproperty
      a_gate_off: assert property (p_gate_off) else $error("disabled clock still toggles");

      property p_full_pulse;
         @(posedge clk_sys) disable iff (sys_rst)
         $changed(enable[n]) |-> $past(phase) && !clock_out[n];
      endproperty
      a_full_pulse: assert property (p_full_pulse) else $error("truncated clock pulse");
   end

endmodule // clock_gate_bank
`default_nettype wire

// *** bridge_error_report.sv ***
`timescale 1ns/1ps
`default_nettype none
module bridge_error_report
   import upstream_window_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire bridge_events_t        events,
   input  wire logic [NUM_EVENTS-1:0] report_disable,
   input  wire logic                  report_enable,
   output logic                       serr_n,
   output var  logic                  serr_oe
);

   logic [NUM_EVENTS-1:0] allowed;

   assign allowed = events & ~report_disable & {NUM_EVENTS{report_enable}};

   // One-cycle low pulse on the open-drain line per reported event
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         serr_oe <= 1'b0;
      end else begin
         serr_oe <= |allowed;
      end
   end

   assign serr_n = ~serr_oe;

   property p_report;
      @(posedge clk_sys) disable iff (sys_rst)
      (report_enable && |(events & ~report_disable)) |=> serr_oe;
   endproperty
   a_report: assert property (p_report) else $error("enabled event not reported");

   property p_suppress;
      @(posedge clk_sys) disable iff (sys_rst)
      (!report_enable || !(|(events & ~report_disable))) |=> !serr_oe;
   endproperty
   a_suppress: assert property (p_suppress) else $error("suppressed event reported");

   c_report: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(serr_oe));

endmodule // bridge_error_report
`default_nettype wire

// *** upstream_window_serr_clock_regs.sv ***
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module upstream_window_serr_clock_regs
   import upstream_window_pkg::*;
#(
   parameter int CLOCK_COUNT = CLOCKS_PER_PORT
) (
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output var  logic [31:0]            wb_dat_o,
   output var  logic                   wb_ack_o,
   input  wire bridge_events_t         bridge_events,
   output logic                        primary_system_error_out_n,
   output logic                        primary_system_error_out_oe,
   output logic [CLOCK_COUNT-1:0]      first_port_clock_out,
   output logic [CLOCK_COUNT-1:0]      second_port_clock_out,
   output var  logic [11:0]            upstream_limit_addr,
   output var  logic [31:0]            upstream_base_upper,
   output var  logic [31:0]            upstream_limit_upper,
   output logic                        irq
);

   if (CLOCK_COUNT != CLOCKS_PER_PORT) begin : g_bad_clocks
      $error("upstream_window_serr_clock_regs: CLOCK_COUNT must be 8");
   end

   logic [15:0]           port1_clock_gating;
   logic [15:0]           port2_clock_gating;
   logic [NUM_EVENTS-1:0] error_report_disable;
   logic                  serr_enable;
   logic [NUM_EVENTS-1:0] irq_status;
   logic [NUM_EVENTS-1:0] irq_mask;
   logic [NUM_EVENTS-1:0] event_bits;
   logic [NUM_EVENTS-1:0] status_clear;
   logic                  clock_phase;
   logic                  bus_request;
   logic                  write_take;
   logic [7:0]            reg_addr;
   logic [31:0]           next_dat;
   logic [31:0]           limit_low_word;
   logic [31:0]           disable_word;
   logic [31:0]           merged;
   logic [31:0]           limit_merged;

   assign reg_addr    = {wb_adr_i[7:2], 2'b00};
   assign bus_request = wb_cyc_i & wb_stb_i;
   // Writes land on the edge where the master sees ack
   assign write_take  = bus_request & wb_we_i & wb_ack_o;
   assign event_bits  = bridge_events;
   assign merged      = apply_sel(READ_ZERO, wb_dat_i, wb_sel_i);
   assign limit_merged = apply_sel(limit_low_word, wb_dat_i, wb_sel_i);

   // Wishbone classic: one wait state, ack for exactly one cycle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_request & ~wb_ack_o;
      end
   end

   assign limit_low_word = {upstream_limit_addr, ADDR64_INDICATOR, 16'h0000};
   assign disable_word   = {24'h000000, 1'b0, error_report_disable, 1'b0};

   always_comb begin
      next_dat = READ_ZERO;
      case (reg_addr)
         OFF_LIMIT_LOW:    next_dat = limit_low_word;
         OFF_BASE_HIGH:    next_dat = upstream_base_upper;
         OFF_LIMIT_HIGH:   next_dat = upstream_limit_upper;
         OFF_ERR_DISABLE:  next_dat = disable_word;
         OFF_PORT1_GATING: next_dat = {16'h0000, port1_clock_gating};
         OFF_PORT2_GATING: next_dat = {16'h0000, port2_clock_gating};
         OFF_ERR_CONTROL:  next_dat = {31'h00000000, serr_enable};
         OFF_IRQ_STATUS:   next_dat = {25'h0000000, irq_status, 1'b0};
         OFF_IRQ_MASK:     next_dat = {25'h0000000, irq_mask, 1'b0};
         default:          next_dat = READ_ZERO;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wb_dat_o <= READ_ZERO;
      end else if (bus_request & ~wb_ack_o) begin
         wb_dat_o <= wb_we_i ? READ_ZERO : next_dat;
      end
   end

   // Upstream window registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         upstream_limit_addr <= LIMIT_ADDR_RESET;
      end else if (write_take && reg_addr == OFF_LIMIT_LOW) begin
         upstream_limit_addr <= limit_merged[LIMIT_ADDR_MSB:LIMIT_ADDR_LSB];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         upstream_base_upper <= UPPER_RESET;
      end else if (write_take && reg_addr == OFF_BASE_HIGH) begin
         upstream_base_upper <= apply_sel(upstream_base_upper, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         upstream_limit_upper <= UPPER_RESET;
      end else if (write_take && reg_addr == OFF_LIMIT_HIGH) begin
         upstream_limit_upper <= apply_sel(upstream_limit_upper, wb_dat_i, wb_sel_i);
      end
   end

   // Error report disables; bits 0 and 7 are not stored
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         error_report_disable <= EVENT_RESET;
      end else if (write_take && reg_addr == OFF_ERR_DISABLE && wb_sel_i[0]) begin
         error_report_disable <= wb_dat_i[EVENT_MSB:EVENT_LSB];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         serr_enable <= SERR_EN_RESET;
      end else if (write_take && reg_addr == OFF_ERR_CONTROL && wb_sel_i[0]) begin
         serr_enable <= wb_dat_i[SERR_ENABLE_BIT];
      end
   end

   // Clock gating fields
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         port1_clock_gating <= GATING_RESET;
      end else if (write_take && reg_addr == OFF_PORT1_GATING) begin
         port1_clock_gating <= merged[GATING_MSB:0] |
                               (port1_clock_gating & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         port2_clock_gating <= GATING_RESET;
      end else if (write_take && reg_addr == OFF_PORT2_GATING) begin
         port2_clock_gating <= merged[GATING_MSB:0] |
                               (port2_clock_gating & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
      end
   end

   // Interrupt status, write one to clear, a new event wins
   assign status_clear = (write_take && reg_addr == OFF_IRQ_STATUS && wb_sel_i[0]) ?
                         wb_dat_i[EVENT_MSB:EVENT_LSB] : EVENT_RESET;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_status <= EVENT_RESET;
      end else begin
         irq_status <= (irq_status & ~status_clear) | event_bits;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_mask <= EVENT_RESET;
      end else if (write_take && reg_addr == OFF_IRQ_MASK && wb_sel_i[0]) begin
         irq_mask <= wb_dat_i[EVENT_MSB:EVENT_LSB];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // Error reporting on the primary bus
   bridge_error_report u_error_report (
      .clk_sys        (clk_sys),
      .sys_rst        (sys_rst),
      .events         (bridge_events),
      .report_disable (error_report_disable),
      .report_enable  (serr_enable),
      .serr_n         (primary_system_error_out_n),
      .serr_oe        (primary_system_error_out_oe)
   );

   // Secondary clocks at half the system rate
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         clock_phase <= 1'b0;
      end else begin
         clock_phase <= ~clock_phase;
      end
   end

   clock_gate_bank #(
      .COUNT (CLOCK_COUNT)
   ) u_port1_clocks (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .phase     (clock_phase),
      .gating    (port1_clock_gating),
      .clock_out (first_port_clock_out)
   );

   clock_gate_bank #(
      .COUNT (CLOCK_COUNT)
   ) u_port2_clocks (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .phase     (clock_phase),
      .gating    (port2_clock_gating),
      .clock_out (second_port_clock_out)
   );

   // Checks
   property p_ack_pulse;
      @(posedge clk_sys) disable iff (sys_rst)
      bus_request && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single cycle after request");

   property p_addr64;
      @(posedge clk_sys) disable iff (sys_rst)
      bus_request && !wb_ack_o && !wb_we_i && reg_addr == OFF_LIMIT_LOW
         |=> wb_dat_o[ADDR64_MSB:ADDR64_LSB] == ADDR64_INDICATOR;
   endproperty
   a_addr64: assert property (p_addr64) else $error("64-bit indicator wrong");

   property p_limit_write;
      @(posedge clk_sys) disable iff (sys_rst)
      write_take && reg_addr == OFF_LIMIT_LOW && wb_sel_i == 4'hf
         |=> upstream_limit_addr == $past(wb_dat_i[LIMIT_ADDR_MSB:LIMIT_ADDR_LSB]);
   endproperty
   a_limit_write: assert property (p_limit_write) else $error("limit address not written");

   property p_base_write;
      @(posedge clk_sys) disable iff (sys_rst)
      write_take && reg_addr == OFF_BASE_HIGH && wb_sel_i == 4'hf |=> upstream_base_upper == $past(wb_dat_i);
   endproperty
   a_base_write: assert property (p_base_write) else $error("base upper not written");

   property p_limit_high_write;
      @(posedge clk_sys) disable iff (sys_rst)
      write_take && reg_addr == OFF_LIMIT_HIGH && wb_sel_i == 4'hf |=> upstream_limit_upper == $past(wb_dat_i);
   endproperty
   a_limit_high_write: assert property (p_limit_high_write) else $error("limit upper not written");

   property p_reserved_zero;
      @(posedge clk_sys) disable iff (sys_rst)
      bus_request && !wb_ack_o && !wb_we_i && reg_addr == OFF_ERR_DISABLE
         |=> wb_dat_o[0] == 1'b0 && wb_dat_o[7] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved disable bits not zero");

   property p_parity_disabled;
      @(posedge clk_sys) disable iff (sys_rst)
      error_report_disable == 6'h01 && event_bits == 6'h01 |=> !primary_system_error_out_oe;
   endproperty
   a_parity_disabled: assert property (p_parity_disabled) else $error("parity report not suppressed");

   property p_abort_reported;
      @(posedge clk_sys) disable iff (sys_rst)
      serr_enable && !error_report_disable[2] && bridge_events.target_abort_posted
         |=> primary_system_error_out_oe;
   endproperty
   a_abort_reported: assert property (p_abort_reported) else $error("target abort not reported");

   property p_irq_set;
      @(posedge clk_sys) disable iff (sys_rst)
      |(event_bits & irq_mask) |=> irq [*2];
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("interrupt not raised by event");

   property p_write_lost_disabled;
      @(posedge clk_sys) disable iff (sys_rst)
      (error_report_disable[1] && event_bits == 6'h02) || (error_report_disable[4] && event_bits == 6'h10)
         |=> !primary_system_error_out_oe;
   endproperty
   a_write_lost_disabled: assert property (p_write_lost_disabled) else $error("write loss reported");

   property p_master_abort_disabled;
      @(posedge clk_sys) disable iff (sys_rst)
      error_report_disable[3] && event_bits == 6'h08 |=> !primary_system_error_out_oe;
   endproperty
   a_master_abort_disabled: assert property (p_master_abort_disabled) else $error("abort reported");

   property p_no_data_disabled;
      @(posedge clk_sys) disable iff (sys_rst)
      error_report_disable[5] && event_bits == 6'h20 |=> !primary_system_error_out_oe;
   endproperty
   a_no_data_disabled: assert property (p_no_data_disabled) else $error("no-data event reported");

   property primary_system_error_out_off;
      @(posedge clk_sys) disable iff (sys_rst)
      !serr_enable |=> !primary_system_error_out_oe;
   endproperty
   a_serr_off: assert property (primary_system_error_out_off) else $error("report while reporting is off");

   property p_reset_values;
      @(posedge clk_sys)
      $fell(sys_rst) |-> upstream_limit_addr == LIMIT_ADDR_RESET && upstream_base_upper == UPPER_RESET
         && upstream_limit_upper == UPPER_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("window reset value wrong");

   property p_status_set;
      @(posedge clk_sys) disable iff (sys_rst)
      |event_bits |=> (irq_status & $past(event_bits)) == $past(event_bits);
   endproperty
   a_status_set: assert property (p_status_set) else $error("event did not set status");

   property p_status_clear;
      @(posedge clk_sys) disable iff (sys_rst)
      write_take && reg_addr == OFF_IRQ_STATUS && wb_sel_i[0] && !(|event_bits)
         |=> (irq_status & $past(wb_dat_i[EVENT_MSB:EVENT_LSB])) == EVENT_RESET;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status bit not cleared");

   property p_gating_write;
      @(posedge clk_sys) disable iff (sys_rst)
      write_take && reg_addr == OFF_PORT2_GATING && wb_sel_i[1:0] == 2'b11
         |=> port2_clock_gating == $past(wb_dat_i[GATING_MSB:0]);
   endproperty
   a_gating_write: assert property (p_gating_write) else $error("port 2 gating not written");

   c_write_base: cover property (@(posedge clk_sys) disable iff (sys_rst)
      write_take && reg_addr == OFF_BASE_HIGH);
   c_clock_off: cover property (@(posedge clk_sys) disable iff (sys_rst)
      clock_disabled(port1_clock_gating[1:0]) [*4]);
   c_irq: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(irq));

endmodule // upstream_window_serr_clock_regs
`default_nettype wire

// *** event_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module event_source_model
   import upstream_window_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic                  slow,
   input  wire logic [NUM_EVENTS-1:0] fire,
   output var  bridge_events_t        events
);
   logic [NUM_EVENTS-1:0] held;

   // Slow mode adds one cycle between request and event pulse
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         held   <= '0;
         events <= '0;
      end else begin
         held   <= fire;
         events <= bridge_events_t'(slow ? held : fire);
      end
   end
endmodule // event_source_model
`default_nettype wire

// *** upstream_window_serr_clock_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module upstream_window_serr_clock_regs_tb;
   import upstream_window_pkg::*;
   localparam int LIMIT = 20000;
   logic                  clk_sys  = 1'b0;
   logic                  sys_rst  = 1'b1;
   logic                  wb_cyc_i = 1'b0;
   logic                  wb_stb_i = 1'b0;
   logic                  wb_we_i  = 1'b0;
   logic [7:0]            wb_adr_i = 8'h00;
   logic [3:0]            wb_sel_i = 4'h0;
   logic [31:0]           wb_dat_i = 32'h0000_0000;
   logic [NUM_EVENTS-1:0] fire     = 6'h00;
   logic                  slow     = 1'b0;
   logic [31:0]           wb_dat_o;
   logic                  wb_ack_o;
   logic                  serr_n;
   logic                  serr_oe;
   logic                  irq;
   bridge_events_t        bridge_events;
   logic [7:0]            clk1;
   logic [7:0]            clk2;
   logic [11:0]           limit_addr;
   logic [31:0]           base_up;
   logic [31:0]           limit_up;
   logic [31:0]           seed     = 32'h0000_cf24;
   logic [31:0]           a;
   logic [31:0]           b;
   logic [31:0]           c;
   logic [31:0]           rd_q[$];
   int                    fail_count = 0;
   int                    checked    = 0;
   int                    cycles     = 0;

   upstream_window_serr_clock_regs #(.CLOCK_COUNT(8)) u_upstream_window_serr_clock_regs (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bridge_events(bridge_events),
      .primary_system_error_out_n(serr_n), .primary_system_error_out_oe(serr_oe),
      .first_port_clock_out(clk1), .second_port_clock_out(clk2), .upstream_limit_addr(limit_addr),
      .upstream_base_upper(base_up), .upstream_limit_upper(limit_up), .irq(irq));

   event_source_model u_event_source_model (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .fire(fire), .events(bridge_events));

   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask

   // Classic single cycle: hold until ack is sampled, then one idle cycle
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      if (wb_ack_o !== 1'b1) begin
         chk("bus_ack", 32'h1, 32'h0);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      bus(1'b1, adr, dat, sel);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      rd_q.push_back(exp);
      bus(1'b0, adr, 32'h0000_0000, 4'hf);
   endtask

   task automatic event_check(input int i, input logic exp_oe, input logic exp_irq);
      int hi;
      hi = 0;
      @(posedge clk_sys);
      fire <= 6'h01 << i;
      @(posedge clk_sys);
      fire <= 6'h00;
      repeat (6) begin
         @(posedge clk_sys);
         if (serr_oe === 1'b1) hi++;
         chk("serr_level", {31'h0, ~serr_oe}, {31'h0, serr_n});
      end
      chk("serr_pulses", {31'h0, exp_oe}, 32'(hi));
      chk("irq_raised", {31'h0, exp_irq}, {31'h0, irq});
   endtask

   task automatic clk_check(input logic [15:0] g1, input logic [15:0] g2);
      logic [7:0] seen1;
      logic [7:0] seen2;
      logic [7:0] off1;
      logic [7:0] off2;
      seen1 = 8'h00;
      seen2 = 8'h00;
      for (int n = 0; n < 8; n++) begin
         off1[n] = g1[2*n] & g1[2*n+1];
         off2[n] = g2[2*n] & g2[2*n+1];
      end
      wr(OFF_PORT1_GATING, {16'h0000, g1}, 4'h3);
      wr(OFF_PORT2_GATING, {16'h0000, g2}, 4'h3);
      rd(OFF_PORT1_GATING, {16'h0000, g1});
      rd(OFF_PORT2_GATING, {16'h0000, g2});
      repeat (6) begin
         @(posedge clk_sys);
         seen1 = seen1 | clk1;
         seen2 = seen2 | clk2;
      end
      chk("port1_clocks", {24'h0, ~off1}, {24'h0, seen1});
      chk("port2_clocks", {24'h0, ~off2}, {24'h0, seen2});
   endtask

   // Read results are matched against the oldest pending note
   always @(posedge clk_sys) begin
      cycles++;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (rd_q.size() == 0) chk("unexpected_read", 32'h0, 32'h1);
         else chk("read_data", rd_q.pop_front(), wb_dat_o);
      end
      if (cycles >= LIMIT) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(OFF_LIMIT_LOW, {LIMIT_ADDR_RESET, ADDR64_INDICATOR, 16'h0000});
      rd(OFF_BASE_HIGH, 32'h0000_0000);
      rd(OFF_LIMIT_HIGH, 32'h0000_0000);
      rd(OFF_ERR_DISABLE, 32'h0000_0000);
      clk_check(16'h0000, 16'h0000);
      $display("done: reset values");
      for (int k = 0; k < 3; k++) begin
         seed = xorshift(seed);
         a = seed;
         seed = xorshift(seed);
         b = seed;
         seed = xorshift(seed);
         c = seed;
         wr(OFF_LIMIT_LOW, a, 4'hf);
         wr(OFF_BASE_HIGH, b, 4'hf);
         wr(OFF_LIMIT_HIGH, c, 4'hf);
         rd(OFF_LIMIT_LOW, {a[31:20], 4'h1, 16'h0000});
         rd(OFF_BASE_HIGH, b);
         rd(OFF_LIMIT_HIGH, c);
         chk("limit_addr", {20'h0, a[31:20]}, {20'h0, limit_addr});
         chk("base_upper", b, base_up);
         chk("limit_upper", c, limit_up);
      end
      seed = xorshift(seed);
      wr(OFF_BASE_HIGH, seed, 4'b0101);
      rd(OFF_BASE_HIGH, {b[31:24], seed[23:16], b[15:8], seed[7:0]});
      wr(8'h70, seed, 4'hf);
      rd(8'h70, 32'h0000_0000);
      wr(OFF_ERR_DISABLE, 32'h0000_00ff, 4'h1);
      rd(OFF_ERR_DISABLE, 32'h0000_007e);
      $display("done: register access");
      wr(OFF_ERR_CONTROL, 32'h0000_0001, 4'h1);
      wr(OFF_IRQ_MASK, 32'h0000_007e, 4'h1);
      rd(OFF_ERR_CONTROL, 32'h0000_0001);
      rd(OFF_IRQ_MASK, 32'h0000_007e);
      for (int i = 0; i < NUM_EVENTS; i++) begin
         for (int d = 0; d < 2; d++) begin
            slow <= i[0];
            wr(OFF_ERR_DISABLE, (d == 1) ? (32'h1 << (i + 1)) : 32'h0, 4'h1);
            event_check(i, d == 0, 1'b1);
            rd(OFF_IRQ_STATUS, 32'h1 << (i + 1));
            wr(OFF_IRQ_STATUS, 32'h1 << (i + 1), 4'h1);
            chk("irq_cleared", 32'h0, {31'h0, irq});
         end
      end
      wr(OFF_ERR_DISABLE, 32'h0000_0000, 4'h1);
      wr(OFF_ERR_CONTROL, 32'h0000_0000, 4'h1);
      event_check(2, 1'b0, 1'b1);
      wr(OFF_IRQ_MASK, 32'h0000_0000, 4'h1);
      event_check(4, 1'b0, 1'b0);
      wr(OFF_IRQ_STATUS, 32'h0000_007e, 4'h1);
      rd(OFF_IRQ_STATUS, 32'h0000_0000);
      $display("done: error reporting");
      clk_check(16'hffff, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         seed = xorshift(seed);
         clk_check(seed[15:0], seed[31:16]);
      end
      clk_check(16'h0000, 16'hffff);
      $display("done: clock gating");
      repeat (2) @(posedge clk_sys);
      chk("pending_reads", 32'h0, 32'(rd_q.size()));
      report_and_stop();
   end
endmodule // upstream_window_serr_clock_regs_tb
`default_nettype wire
